// [design/clb_alu.sv]
// result and flag logic for the one-cycle register operations
`timescale 1ns/1ps
`default_nettype none
`include "clb_params.svh"
module clb_alu
(
  // operation and operands
  input  wire clb_pkg::clb_op_t op,
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       b,
  input  wire logic             c_in,
  // result
  output logic [7:0]            res,
  output logic                  wr,
  output logic                  upd_znv,
  output logic                  upd_c,
  output logic                  c_out,
  output logic                  v_out
);
  always_comb
  begin
    res     = a;
    wr      = 1'b1;
    upd_znv = 1'b1;
    upd_c   = 1'b0;
    c_out   = c_in;
    v_out   = 1'b0;
    case (op)
      clb_pkg::EXCLUSIVE_OR_OP:     res = a ^ b;
      clb_pkg::OR_MASK_OP:          res = a | b;
      clb_pkg::AND_NOT_MASK_OP:     res = a & (`CLB_ALL_ONES - b);
      clb_pkg::ADD_ONE_OP:
      begin
        res   = a + 8'h01;
        v_out = (res == 8'h80);
      end
      clb_pkg::SUB_ONE_OP:
      begin
        res   = a - 8'h01;
        v_out = (res == 8'h7f);
      end
      clb_pkg::TEST_VALUE_OP:
      begin
        res = a & a;
        wr  = 1'b0;
      end
      clb_pkg::ZERO_REGISTER_OP:    res = a ^ a;
      clb_pkg::ALL_ONES_OP:
      begin
        res     = `CLB_ALL_ONES;
        upd_znv = 1'b0;
      end
      clb_pkg::SHIFT_LEFT_LOGICAL:
      begin
        res   = {a[6:0], 1'b0};
        upd_c = 1'b1;
        c_out = a[7];
        v_out = res[7] ^ a[7];
      end
      clb_pkg::SHIFT_RIGHT_LOGICAL:
      begin
        res   = {1'b0, a[7:1]};
        upd_c = 1'b1;
        c_out = a[0];
        v_out = a[0];
      end
      clb_pkg::ROTATE_LEFT_CARRY:
      begin
        res   = {a[6:0], c_in};
        upd_c = 1'b1;
        c_out = a[7];
        v_out = res[7] ^ a[7];
      end
      default:
      begin
        wr      = 1'b0;
        upd_znv = 1'b0;
      end
    endcase
  end
endmodule // clb_alu
`default_nettype wire

// [design/clb_core.sv]
// execution slice: register file, status flags, program counter and sequencing
`timescale 1ns/1ps
`default_nettype none
`include "clb_params.svh"
module clb_core
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // decoded operation
  input  wire logic             op_valid,
  input  wire clb_pkg::clb_op_t op_code,
  input  wire logic [4:0]       op_rd,
  input  wire logic [4:0]       op_rr,
  input  wire logic [7:0]       op_imm,
  input  wire logic [2:0]       op_bit,
  input  wire logic [4:0]       op_io,
  input  wire logic [11:0]      op_offset,
  input  wire logic             op_next_long,
  output logic                  op_ready,
  // writes from the rest of the core
  input  wire logic             ext_rf_we,
  input  wire logic [4:0]       ext_rf_addr,
  input  wire logic [7:0]       ext_rf_wdata,
  input  wire logic             ext_sr_we,
  input  wire logic [7:0]       ext_sr_wdata,
  // observation
  input  wire logic [4:0]       peek_addr,
  output logic [7:0]            peek_data,
  output logic [15:0]           pc,
  output logic [7:0]            status_flags,
  output logic [15:0]           sp,
  // stack memory
  output logic                  stk_we,
  output logic [15:0]           stk_addr,
  output logic [7:0]            stk_wdata,
  // io register space
  output logic [4:0]            io_rd_addr,
  input  wire logic [7:0]       io_rdata,
  output logic                  io_bit_we,
  output logic [4:0]            io_bit_addr,
  output logic [2:0]            io_bit_idx,
  output logic                  io_bit_val
);
  clb_pkg::clb_core_t cur;
  clb_pkg::clb_core_t next_cur;

  logic       acc;
  logic [7:0] rd_val;
  logic [7:0] rr_val;
  logic [7:0] alu_res;
  logic       alu_wr;
  logic       alu_znv;
  logic       alu_c;
  logic       alu_cout;
  logic       alu_v;
  logic       flag_sel;
  logic       br_cond;
  logic       skip;
  logic       is_branch;
  logic [15:0] seq_pc;
  logic [15:0] rel_pc;
  logic [15:0] ptr;

  assign op_ready = (cur.st == clb_pkg::ST_EXEC);
  assign acc      = op_valid && op_ready;
  assign rd_val   = cur.rf[op_rd];
  assign rr_val   = cur.rf[op_rr];
  assign ptr      = {cur.rf[`CLB_PTR_HI], cur.rf[`CLB_PTR_LO]};
  assign seq_pc   = cur.pc + 16'h0001;
  // offset is sign extended before the add so backward targets wrap correctly
  assign rel_pc   = cur.pc + {{4{op_offset[11]}}, op_offset} + 16'h0001;
  // only the five-bit io window is reachable by the bit operations
  assign io_rd_addr = op_io;

  clb_alu u_alu
  (
    .op      (op_code),
    .a       (rd_val),
    .b       ((op_code == clb_pkg::EXCLUSIVE_OR_OP) ? rr_val : op_imm),
    .c_in    (cur.sr[`CLB_FLAG_C]),
    .res     (alu_res),
    .wr      (alu_wr),
    .upd_znv (alu_znv),
    .upd_c   (alu_c),
    .c_out   (alu_cout),
    .v_out   (alu_v)
  );

  // the decoder maps equal, carry, minus, half carry, transfer, overflow
  // and interrupt branches onto a flag index
  always_comb
  begin
    flag_sel  = cur.sr[op_bit];
    br_cond   = 1'b0;
    is_branch = 1'b1;
    case (op_code)
      clb_pkg::BRANCH_FLAG_HIGH: br_cond = flag_sel;
      clb_pkg::BRANCH_FLAG_LOW:  br_cond = !flag_sel;
      clb_pkg::BRANCH_SIGNED_GE:
        br_cond = !(cur.sr[`CLB_FLAG_N] ^ cur.sr[`CLB_FLAG_V]);
      clb_pkg::BRANCH_SIGNED_LT:
        br_cond = cur.sr[`CLB_FLAG_N] ^ cur.sr[`CLB_FLAG_V];
      default:                   is_branch = 1'b0;
    endcase
  end

  always_comb
  begin
    case (op_code)
      clb_pkg::COMPARE_SKIP_EQUAL: skip = (rd_val == rr_val);
      clb_pkg::SKIP_REG_BIT_LOW:   skip = !rr_val[op_bit];
      clb_pkg::SKIP_REG_BIT_HIGH:  skip = rr_val[op_bit];
      clb_pkg::SKIP_IO_BIT_LOW:    skip = !io_rdata[op_bit];
      clb_pkg::SKIP_IO_BIT_HIGH:   skip = io_rdata[op_bit];
      default:                     skip = 1'b0;
    endcase
  end

  always_comb
  begin
    next_cur        = cur;
    next_cur.stk_we = 1'b0;
    next_cur.io_we  = 1'b0;
    next_cur.peek   = cur.rf[peek_addr];
    case (cur.st)
      clb_pkg::ST_EXEC:
      begin
        if (acc)
        begin
          next_cur.pc = seq_pc;
          if (alu_wr)
            next_cur.rf[op_rd] = alu_res;
          if (alu_znv)
          begin
            next_cur.sr[`CLB_FLAG_Z] = (alu_res == 8'h00);
            next_cur.sr[`CLB_FLAG_N] = alu_res[7];
            next_cur.sr[`CLB_FLAG_V] = alu_v;
          end
          // carry moves only for shifts and rotate
          if (alu_c)
            next_cur.sr[`CLB_FLAG_C] = alu_cout;
          if (is_branch && br_cond)
          begin
            next_cur.pc  = rel_pc;
            next_cur.st  = clb_pkg::ST_STALL;
            next_cur.rem = `CLB_REM_2CYC;
          end
          if (skip)
          begin
            next_cur.pc  = op_next_long ? cur.pc + 16'h0003 : cur.pc + 16'h0002;
            next_cur.st  = clb_pkg::ST_STALL;
            next_cur.rem = op_next_long ? `CLB_REM_3CYC : `CLB_REM_2CYC;
          end
          case (op_code)
            clb_pkg::RELATIVE_JUMP:
            begin
              next_cur.pc  = rel_pc;
              next_cur.st  = clb_pkg::ST_STALL;
              next_cur.rem = `CLB_REM_2CYC;
            end
            clb_pkg::JUMP_VIA_POINTER:
            begin
              next_cur.pc  = ptr;
              next_cur.st  = clb_pkg::ST_STALL;
              next_cur.rem = `CLB_REM_2CYC;
            end
            clb_pkg::RELATIVE_CALL, clb_pkg::CALL_VIA_POINTER:
            begin
              // low byte goes first, high byte follows in the push state
              next_cur.pc        = (op_code == clb_pkg::RELATIVE_CALL) ? rel_pc : ptr;
              next_cur.stk_we    = 1'b1;
              next_cur.stk_addr  = cur.sp;
              next_cur.stk_wdata = seq_pc[7:0];
              next_cur.ret_hi    = seq_pc[15:8];
              next_cur.sp        = cur.sp - 16'h0001;
              next_cur.st        = clb_pkg::ST_PUSH;
            end
            clb_pkg::SET_IO_BIT, clb_pkg::CLEAR_IO_BIT:
            begin
              // a single-bit write keeps write-one-to-clear neighbours intact
              next_cur.io_we   = 1'b1;
              next_cur.io_addr = op_io;
              next_cur.io_idx  = op_bit;
              next_cur.io_val  = (op_code == clb_pkg::SET_IO_BIT);
              next_cur.st      = clb_pkg::ST_STALL;
              next_cur.rem     = `CLB_REM_2CYC;
            end
            default:
            begin
            end
          endcase
        end
      end
      clb_pkg::ST_PUSH:
      begin
        next_cur.stk_we    = 1'b1;
        next_cur.stk_addr  = cur.sp;
        next_cur.stk_wdata = cur.ret_hi;
        next_cur.sp        = cur.sp - 16'h0001;
        next_cur.st        = clb_pkg::ST_STALL;
        next_cur.rem       = `CLB_REM_2CYC;
      end
      clb_pkg::ST_STALL:
      begin
        if (cur.rem == 2'h0)
          next_cur.st = clb_pkg::ST_EXEC;
        else
          next_cur.rem = cur.rem - 2'h1;
      end
      default:   next_cur.st = clb_pkg::ST_EXEC;
    endcase
    // outside writes yield to an instruction taken in the same cycle
    if (ext_rf_we && !(acc && alu_wr && (op_rd == ext_rf_addr)))
      next_cur.rf[ext_rf_addr] = ext_rf_wdata;
    if (ext_sr_we && !acc)
      next_cur.sr = ext_sr_wdata;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur           <= '0;
      cur.st        <= clb_pkg::ST_EXEC;
      cur.pc        <= `CLB_PC_RST;
      cur.sr        <= `CLB_SR_RST;
      cur.sp        <= `CLB_SP_RST;
    end
    else
      cur <= next_cur;
  end

  assign pc           = cur.pc;
  assign status_flags = cur.sr;
  assign sp           = cur.sp;
  assign peek_data    = cur.peek;
  assign stk_we       = cur.stk_we;
  assign stk_addr     = cur.stk_addr;
  assign stk_wdata    = cur.stk_wdata;
  assign io_bit_we    = cur.io_we;
  assign io_bit_addr  = cur.io_addr;
  assign io_bit_idx   = cur.io_idx;
  assign io_bit_val   = cur.io_val;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_xor_pc_step: assert property (acc && op_code == clb_pkg::EXCLUSIVE_OR_OP
    |=> pc == $past(pc) + 16'h0001 && op_ready)
    else $error("xor did not finish in one cycle");
  a_inc_carry: assert property (acc && op_code == clb_pkg::ADD_ONE_OP
    |=> status_flags[0] == $past(status_flags[0]))
    else $error("add one changed carry");
  a_ser_no_flags: assert property (acc && op_code == clb_pkg::ALL_ONES_OP && !ext_sr_we
    |=> $stable(status_flags))
    else $error("all ones changed flags");
  a_jump_two: assert property (acc && op_code == clb_pkg::JUMP_VIA_POINTER
    |=> !op_ready ##1 op_ready)
    else $error("pointer jump not two cycles");
  a_call_push: assert property (acc && op_code == clb_pkg::RELATIVE_CALL
    |=> stk_we && !op_ready ##1 stk_we && !op_ready ##1 op_ready && !stk_we)
    else $error("call push or timing wrong");
  a_skip_long: assert property (acc && skip && op_next_long
    |=> (!op_ready)[*2] ##1 op_ready)
    else $error("long skip not three cycles");
  a_branch_idle: assert property (acc && is_branch && !br_cond
    |=> op_ready && pc == $past(pc) + 16'h0001)
    else $error("untaken branch wrong");
  a_io_bit_set: assert property (acc && op_code == clb_pkg::SET_IO_BIT
    |=> io_bit_we && io_bit_val && io_bit_addr == $past(op_io) ##1 !io_bit_we && op_ready)
    else $error("io bit set wrong");
  a_lsr_carry: assert property (acc && op_code == clb_pkg::SHIFT_RIGHT_LOGICAL
    |=> status_flags[0] == $past(rd_val[0]) && !status_flags[2])
    else $error("shift right flags wrong");

  a_or_mask_res: assert property (acc && op_code == clb_pkg::OR_MASK_OP
    |=> cur.rf[$past(op_rd)] == ($past(rd_val) | $past(op_imm)))
    else $error("or mask result wrong");

  a_and_not_res: assert property (acc && op_code == clb_pkg::AND_NOT_MASK_OP
    |=> cur.rf[$past(op_rd)] == ($past(rd_val) & ~$past(op_imm)))
    else $error("and not mask result wrong");

  a_dec_result: assert property (acc && op_code == clb_pkg::SUB_ONE_OP
    |=> cur.rf[$past(op_rd)] == $past(rd_val) - 8'h01
        && status_flags[0] == $past(status_flags[0]))
    else $error("subtract one wrong");

  a_test_keep: assert property (acc && op_code == clb_pkg::TEST_VALUE_OP && !ext_rf_we
    |=> cur.rf[$past(op_rd)] == $past(rd_val) && !status_flags[3]
        && status_flags[1] == ($past(rd_val) == 8'h00))
    else $error("test changed value or flags wrong");

  a_clr_zero: assert property (acc && op_code == clb_pkg::ZERO_REGISTER_OP
    |=> cur.rf[$past(op_rd)] == 8'h00 && status_flags[1] && !status_flags[2] && !status_flags[3])
    else $error("zero register wrong");

  a_jump_via_pointer_target: assert property (acc && op_code == clb_pkg::JUMP_VIA_POINTER
    |=> pc == {$past(cur.rf[`CLB_PTR_HI]), $past(cur.rf[`CLB_PTR_LO])})
    else $error("pointer jump target wrong");

  a_call_via_pointer_lo: assert property (acc && op_code == clb_pkg::CALL_VIA_POINTER
    |=> pc == {$past(cur.rf[`CLB_PTR_HI]), $past(cur.rf[`CLB_PTR_LO])}
        && stk_addr == $past(sp) && stk_wdata == $past(pc[7:0]) + 8'h01)
    else $error("pointer call target or push wrong");

  a_relative_jump_target: assert property (acc && op_code == clb_pkg::RELATIVE_JUMP
    |=> pc == $past(pc) + {{4{$past(op_offset[11])}}, $past(op_offset)} + 16'h0001
        && !op_ready ##1 op_ready)
    else $error("relative jump wrong");

  a_skip_short: assert property (acc && skip && !op_next_long
    |=> pc == $past(pc) + 16'h0002 && !op_ready ##1 op_ready)
    else $error("short skip wrong");

  a_reg_noskip: assert property (acc && op_code == clb_pkg::SKIP_REG_BIT_LOW && rr_val[op_bit]
    |=> op_ready && pc == $past(pc) + 16'h0001)
    else $error("register bit skip taken on set bit");

  a_io_skip: assert property (acc && op_code == clb_pkg::SKIP_IO_BIT_HIGH && io_rdata[op_bit]
    |=> !op_ready)
    else $error("io bit skip not taken");

  a_br_taken: assert property (acc && op_code == clb_pkg::BRANCH_FLAG_HIGH && status_flags[op_bit]
    |=> pc == $past(pc) + {{4{$past(op_offset[11])}}, $past(op_offset)} + 16'h0001
        && !op_ready)
    else $error("taken flag branch wrong");

  a_br_carry: assert property (acc && op_code == clb_pkg::BRANCH_FLAG_LOW
    && op_bit == `CLB_FLAG_C && status_flags[0] |=> op_ready)
    else $error("carry low branch taken on carry");

  a_br_zero: assert property (acc && op_code == clb_pkg::BRANCH_FLAG_HIGH
    && op_bit == `CLB_FLAG_Z && !status_flags[1] |=> op_ready)
    else $error("equal branch taken on nonzero");

  a_br_signed: assert property (acc && op_code == clb_pkg::BRANCH_SIGNED_LT
    && (status_flags[2] == status_flags[3]) |=> op_ready && pc == $past(pc) + 16'h0001)
    else $error("signed less branch wrong");

  a_io_clear: assert property (acc && op_code == clb_pkg::CLEAR_IO_BIT
    |=> io_bit_we && !io_bit_val && io_bit_idx == $past(op_bit) && $stable(status_flags))
    else $error("io bit clear wrong");

  a_rol_flags: assert property (acc && op_code == clb_pkg::ROTATE_LEFT_CARRY
    |=> cur.rf[$past(op_rd)] == {$past(rd_val[6:0]), $past(status_flags[0])}
        && status_flags[0] == $past(rd_val[7]))
    else $error("rotate through carry wrong");

endmodule // clb_core
`default_nettype wire

// [design/clb_params.svh]
// constants for the logic, branch and bit-operation execution slice
`ifndef CLB_PARAMS_SVH
`define CLB_PARAMS_SVH
`define CLB_FLAG_C 3'h0
`define CLB_FLAG_Z 3'h1
`define CLB_FLAG_N 3'h2
`define CLB_FLAG_V 3'h3
`define CLB_FLAG_S 3'h4
`define CLB_FLAG_H 3'h5
`define CLB_FLAG_T 3'h6
`define CLB_FLAG_I 3'h7
`define CLB_ALL_ONES 8'hff
`define CLB_SR_RST 8'h00
`define CLB_PC_RST 16'h0000
`define CLB_SP_RST 16'h01ff
`define CLB_PTR_LO 5'h1e
`define CLB_PTR_HI 5'h1f
`define CLB_IO_BIT_MAX 5'h1f
`define CLB_REM_2CYC 2'h0
`define CLB_REM_3CYC 2'h1
`endif

// [design/clb_pkg.sv]
// types for the logic, branch and bit-operation execution slice
`default_nettype none
package clb_pkg;
  typedef enum logic [4:0] {
    NOP_OP, EXCLUSIVE_OR_OP, OR_MASK_OP, AND_NOT_MASK_OP, ADD_ONE_OP,
    SUB_ONE_OP, TEST_VALUE_OP, ZERO_REGISTER_OP, ALL_ONES_OP,
    SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL, ROTATE_LEFT_CARRY,
    RELATIVE_JUMP, JUMP_VIA_POINTER, RELATIVE_CALL, CALL_VIA_POINTER,
    COMPARE_SKIP_EQUAL, SKIP_REG_BIT_LOW, SKIP_REG_BIT_HIGH,
    SKIP_IO_BIT_LOW, SKIP_IO_BIT_HIGH, BRANCH_FLAG_HIGH, BRANCH_FLAG_LOW,
    BRANCH_SIGNED_GE, BRANCH_SIGNED_LT, SET_IO_BIT, CLEAR_IO_BIT
  } clb_op_t;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_PUSH  = 3'b010,
    ST_STALL = 3'b100
  } clb_state_t;

  typedef struct packed {
    clb_state_t      st;
    logic [1:0]      rem;
    logic [15:0]     pc;
    logic [7:0]      sr;
    logic [15:0]     sp;
    logic [7:0]      ret_hi;
    logic            stk_we;
    logic [15:0]     stk_addr;
    logic [7:0]      stk_wdata;
    logic            io_we;
    logic [4:0]      io_addr;
    logic [2:0]      io_idx;
    logic            io_val;
    logic [7:0]      peek;
    logic [31:0][7:0] rf;
  } clb_core_t;
endpackage
`default_nettype wire

// [test/clb_io_model.sv]
// io register space and stack memory seen by the execution slice
`timescale 1ns/1ps
`default_nettype none
module clb_io_model
(
  // clock
  input  wire logic        sys_clk,
  // io register space
  input  wire logic [4:0]  io_rd_addr,
  output logic [7:0]       io_rdata,
  input  wire logic        io_bit_we,
  input  wire logic [4:0]  io_bit_addr,
  input  wire logic [2:0]  io_bit_idx,
  input  wire logic        io_bit_val,
  // stack memory
  input  wire logic        stk_we,
  input  wire logic [15:0] stk_addr,
  input  wire logic [7:0]  stk_wdata
);
  logic [7:0] io_reg  [32];
  logic [7:0] stk_mem [512];
  // distinct start values so a wrong address shows up
  initial
  begin
    for (int i = 0; i < 32; i++)
      io_reg[i] = 8'ha5 ^ 8'(i * 7);
  end
  // reads answer in the same cycle, as the core expects
  assign io_rdata = io_reg[io_rd_addr];
  // only the addressed bit moves, so clear-on-one flags beside it survive
  always @(posedge sys_clk)
  begin
    if (io_bit_we)
      io_reg[io_bit_addr][io_bit_idx] <= io_bit_val;
    if (stk_we)
      stk_mem[stk_addr[8:0]] <= stk_wdata;
  end
endmodule // clb_io_model
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the execution slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic             sys_clk = 1'b0;
  logic             rstn = 1'b0;
  logic             op_valid = 1'b0;
  clb_pkg::clb_op_t op_code = clb_pkg::NOP_OP;
  logic [4:0]       op_rd = 5'h00;
  logic [4:0]       op_rr = 5'h00;
  logic [7:0]       op_imm = 8'h00;
  logic [2:0]       op_bit = 3'h0;
  logic [4:0]       op_io = 5'h00;
  logic [11:0]      op_offset = 12'h000;
  logic             op_next_long = 1'b0;
  logic             ext_rf_we = 1'b0;
  logic [4:0]       ext_rf_addr = 5'h00;
  logic [7:0]       ext_rf_wdata = 8'h00;
  logic             ext_sr_we = 1'b0;
  logic [7:0]       ext_sr_wdata = 8'h00;
  logic [4:0]       peek_addr = 5'h00;
  logic             op_ready, stk_we, io_bit_we, io_bit_val;
  logic [7:0]       peek_data, status_flags, stk_wdata, io_rdata;
  logic [15:0]      pc, sp, stk_addr, pc_m, sp_m;
  logic [4:0]       io_rd_addr, io_bit_addr;
  logic [2:0]       io_bit_idx;
  logic [7:0]       rf_m [32];
  logic [7:0]       sr_m;
  int               bad_count = 0;
  int               check_count = 0;
  clb_pkg::clb_op_t alu_op [11] = '{clb_pkg::EXCLUSIVE_OR_OP, clb_pkg::OR_MASK_OP,
    clb_pkg::AND_NOT_MASK_OP, clb_pkg::ADD_ONE_OP, clb_pkg::SUB_ONE_OP,
    clb_pkg::TEST_VALUE_OP, clb_pkg::ZERO_REGISTER_OP, clb_pkg::ALL_ONES_OP,
    clb_pkg::SHIFT_LEFT_LOGICAL, clb_pkg::SHIFT_RIGHT_LOGICAL, clb_pkg::ROTATE_LEFT_CARRY};
  clb_pkg::clb_op_t crn_op [4] = '{clb_pkg::ADD_ONE_OP, clb_pkg::SUB_ONE_OP,
    clb_pkg::SHIFT_LEFT_LOGICAL, clb_pkg::SHIFT_RIGHT_LOGICAL};
  logic [7:0]       crn_a [4] = '{8'h7f, 8'h80, 8'h80, 8'h01};
  clb_pkg::clb_op_t skp [5] = '{clb_pkg::COMPARE_SKIP_EQUAL, clb_pkg::SKIP_REG_BIT_LOW,
    clb_pkg::SKIP_REG_BIT_HIGH, clb_pkg::SKIP_IO_BIT_LOW, clb_pkg::SKIP_IO_BIT_HIGH};

  always #12.5 sys_clk = ~sys_clk;

  clb_core i_clb_core (.sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .op_rd(op_rd), .op_rr(op_rr), .op_imm(op_imm), .op_bit(op_bit),
    .op_io(op_io), .op_offset(op_offset), .op_next_long(op_next_long),
    .op_ready(op_ready), .ext_rf_we(ext_rf_we), .ext_rf_addr(ext_rf_addr),
    .ext_rf_wdata(ext_rf_wdata), .ext_sr_we(ext_sr_we), .ext_sr_wdata(ext_sr_wdata),
    .peek_addr(peek_addr), .peek_data(peek_data), .pc(pc), .status_flags(status_flags),
    .sp(sp), .stk_we(stk_we), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .io_rd_addr(io_rd_addr), .io_rdata(io_rdata), .io_bit_we(io_bit_we),
    .io_bit_addr(io_bit_addr), .io_bit_idx(io_bit_idx), .io_bit_val(io_bit_val));

  clb_io_model i_clb_io_model (.sys_clk(sys_clk), .io_rd_addr(io_rd_addr),
    .io_rdata(io_rdata), .io_bit_we(io_bit_we), .io_bit_addr(io_bit_addr),
    .io_bit_idx(io_bit_idx), .io_bit_val(io_bit_val), .stk_we(stk_we),
    .stk_addr(stk_addr), .stk_wdata(stk_wdata));

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [15:0] sx(input logic [11:0] o);
    return {{4{o[11]}}, o};
  endfunction

  // expected {flags, result}; S and H are left alone by this group
  function automatic logic [15:0] alu_f(input clb_pkg::clb_op_t c,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] k, input logic [7:0] s);
    logic [7:0] r;
    logic [7:0] f;
    f = s;
    r = a;
    case (c)
      clb_pkg::EXCLUSIVE_OR_OP:     r = a ^ b;
      clb_pkg::OR_MASK_OP:          r = a | k;
      clb_pkg::AND_NOT_MASK_OP:     r = a & (8'hff - k);
      clb_pkg::ADD_ONE_OP:          r = a + 8'h01;
      clb_pkg::SUB_ONE_OP:          r = a - 8'h01;
      clb_pkg::ZERO_REGISTER_OP:    r = 8'h00;
      clb_pkg::ALL_ONES_OP:         r = 8'hff;
      clb_pkg::SHIFT_LEFT_LOGICAL:  {f[0], r} = {a, 1'b0};
      clb_pkg::SHIFT_RIGHT_LOGICAL: {r, f[0]} = {1'b0, a};
      clb_pkg::ROTATE_LEFT_CARRY:   {f[0], r} = {a, s[0]};
      default:                      r = a;
    endcase
    if (c != clb_pkg::ALL_ONES_OP)
    begin
      f[1] = (r == 8'h00);
      f[2] = r[7];
      f[3] = (c == clb_pkg::ADD_ONE_OP) ? (r == 8'h80) : (c == clb_pkg::SUB_ONE_OP) ?
        (r == 8'h7f) : (c >= clb_pkg::SHIFT_LEFT_LOGICAL) ? (r[7] ^ f[0]) : 1'b0;
    end
    return {f, r};
  endfunction

  task automatic wr_rf(input logic [4:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    ext_rf_we <= 1'b1;
    ext_rf_addr <= a;
    ext_rf_wdata <= v;
    rf_m[a] = v;
    @(posedge sys_clk);
    ext_rf_we <= 1'b0;
  endtask

  task automatic set_sr(input logic [7:0] v);
    @(posedge sys_clk);
    ext_sr_we <= 1'b1;
    ext_sr_wdata <= v;
    sr_m = v;
    @(posedge sys_clk);
    ext_sr_we <= 1'b0;
  endtask

  task automatic peek(input logic [4:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    peek_addr <= a;
    @(posedge sys_clk);
    #1 v = peek_data;
  endtask

  // offer one operation, then count cycles until the core takes the next
  task automatic run_op(input clb_pkg::clb_op_t c, input logic [4:0] rd, input logic [4:0] rr,
    input logic [7:0] k, input logic [2:0] b, input logic [4:0] io, input logic [11:0] off,
    input logic lng, output int n);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_rd <= rd;
    op_rr <= rr;
    op_imm <= k;
    op_bit <= b;
    op_io <= io;
    op_offset <= off;
    op_next_long <= lng;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 n = 1;
    while (op_ready !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 8)
    begin
      bad_count++;
      close_out();
    end
  endtask

  task automatic post(input int n, input int ncyc, input logic [15:0] epc);
    chk("cycles", 16'(n), 16'(ncyc));
    chk("pc", pc, epc);
    chk("flags", {8'h00, status_flags}, {8'h00, sr_m});
    pc_m = epc;
  endtask

  initial
  begin
    int n;
    int nc;
    logic [7:0] a;
    logic [7:0] v;
    logic [7:0] k;
    logic [15:0] r;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [4:0] io;
    logic [2:0] b;
    logic [11:0] off;
    logic t;
    clb_pkg::clb_op_t c;
    n = $urandom(87);
    repeat (12) @(posedge sys_clk);
    chk("reset pc", pc, 16'h0000);
    chk("reset sp", sp, 16'h01ff);
    chk("reset flags", {8'h00, status_flags}, 16'h0000);
    chk("reset ready", {15'h0000, op_ready}, 16'h0001);
    rstn <= 1'b1;
    foreach (rf_m[i]) rf_m[i] = 8'h00;
    {sr_m, pc_m, sp_m} = {8'h00, 16'h0000, 16'h01ff};
    for (int i = 0; i < 40; i++)
    begin
      c = (i < 4) ? crn_op[i] : (i < 15) ? alu_op[i - 4] : alu_op[$urandom % 11];
      {rd, rr, k} = 18'($urandom);
      wr_rf(rr, 8'($urandom));
      wr_rf(rd, (i < 4) ? crn_a[i] : 8'($urandom));
      set_sr(8'($urandom));
      r = alu_f(c, rf_m[rd], rf_m[rr], k, sr_m);
      run_op(c, rd, rr, k, 3'h0, 5'h00, 12'h000, 1'b0, n);
      {sr_m, rf_m[rd]} = r;
      post(n, 1, pc_m + 16'h0001);
      peek(rd, v);
      chk("register", {8'h00, v}, {8'h00, r[7:0]});
    end
    for (int i = 0; i < 24; i++)
    begin
      set_sr(8'($urandom));
      b = 3'(i % 8);
      off = 12'($urandom);
      c = (i < 8) ? clb_pkg::BRANCH_FLAG_HIGH : (i < 16) ? clb_pkg::BRANCH_FLAG_LOW :
        i[0] ? clb_pkg::BRANCH_SIGNED_LT : clb_pkg::BRANCH_SIGNED_GE;
      t = (i < 8) ? sr_m[b] : (i < 16) ? !sr_m[b] : ((sr_m[2] ^ sr_m[3]) ~^ i[0]);
      run_op(c, 5'h00, 5'h00, 8'h00, b, 5'h00, off, 1'b0, n);
      r = t ? pc_m + sx(off) + 16'h0001 : pc_m + 16'h0001;
      post(n, t ? 2 : 1, r);
    end
    wr_rf(5'h1e, 8'($urandom));
    wr_rf(5'h1f, 8'($urandom));
    run_op(clb_pkg::JUMP_VIA_POINTER, 5'h00, 5'h00, 8'h00, 3'h0, 5'h00, 12'h000, 1'b0, n);
    post(n, 2, {rf_m[31], rf_m[30]});
    run_op(clb_pkg::RELATIVE_JUMP, 5'h00, 5'h00, 8'h00, 3'h0, 5'h00, 12'h800, 1'b0, n);
    post(n, 2, pc_m + sx(12'h800) + 16'h0001);
    for (int j = 0; j < 2; j++)
    begin
      r = pc_m + 16'h0001;
      c = j[0] ? clb_pkg::CALL_VIA_POINTER : clb_pkg::RELATIVE_CALL;
      run_op(c, 5'h00, 5'h00, 8'h00, 3'h0, 5'h00, 12'h7ff, 1'b0, n);
      post(n, 3, j[0] ? {rf_m[31], rf_m[30]} : pc_m + sx(12'h7ff) + 16'h0001);
      chk("ret lo", {8'h00, i_clb_io_model.stk_mem[9'(sp_m)]}, {8'h00, r[7:0]});
      chk("ret hi", {8'h00, i_clb_io_model.stk_mem[9'(sp_m - 16'h1)]}, {8'h00, r[15:8]});
      sp_m = sp_m - 16'h0002;
      chk("sp", sp, sp_m);
    end
    // an offer made while the core is stalled must leave no trace
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= clb_pkg::RELATIVE_JUMP;
    op_offset <= 12'h004;
    @(posedge sys_clk);
    op_code <= clb_pkg::ALL_ONES_OP;
    op_rd <= 5'h05;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 chk("refused pc", pc, pc_m + 16'h0005);
    pc_m = pc_m + 16'h0005;
    peek(5'h05, v);
    chk("refused reg", {8'h00, v}, {8'h00, rf_m[5]});
    for (int i = 0; i < 20; i++)
    begin
      c = skp[i % 5];
      {rd, rr, io, b} = 18'($urandom);
      wr_rf(rd, 8'($urandom));
      wr_rf(rr, i[1] ? rf_m[rd] : 8'($urandom));
      a = i_clb_io_model.io_reg[io];
      case (i % 5)
        0:       t = (rf_m[rd] == rf_m[rr]);
        1:       t = !rf_m[rr][b];
        2:       t = rf_m[rr][b];
        3:       t = !a[b];
        default: t = a[b];
      endcase
      nc = t ? 2 + int'(i[2]) : 1;
      run_op(c, rd, rr, 8'h00, b, io, 12'h000, i[2], n);
      post(n, nc, pc_m + 16'(nc));
    end
    for (int i = 0; i < 6; i++)
    begin
      {io, b} = 8'($urandom);
      if (i == 0)
        io = 5'h1f;
      a = i_clb_io_model.io_reg[io];
      v = i_clb_io_model.io_reg[io ^ 5'h01];
      c = i[0] ? clb_pkg::CLEAR_IO_BIT : clb_pkg::SET_IO_BIT;
      run_op(c, 5'h00, 5'h00, 8'h00, b, io, 12'h000, 1'b0, n);
      post(n, 2, pc_m + 16'h0001);
      a[b] = !i[0];
      chk("io bit", {8'h00, i_clb_io_model.io_reg[io]}, {8'h00, a});
      chk("io other", {8'h00, i_clb_io_model.io_reg[io ^ 5'h01]}, {8'h00, v});
    end
    close_out();
  end
endmodule // tb_top
`default_nettype wire
